// [mtmc_core.sv]
/*
 Training mode control: write leveling, output off, per-device MRS
 qualification and input reference calibration fields, with an
 AXI4-Lite register port.
 Assumes controller pins are asynchronous to clk_sys and that the link
 clock is several times slower than clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtmc_defines.svh"

module mtmc_core #(
    parameter int ADDR_W      = 8,
    parameter int MOD_CK      = `MTMC_MOD_CK,
    parameter int PDA_WAIT_CK = `MTMC_PDA_WAIT_CK
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              pin_ck,
    input  wire logic              pin_mrs_n,
    input  wire logic [2:0]        pin_ba,
    input  wire logic [13:0]       pin_a,
    input  wire logic              pin_dqs,
    input  wire logic              pin_dq0,
    input  wire logic              pin_odt,
    output var  logic [7:0]        dq_out,
    output var  logic              dq_oe,
    output var  logic              rtt_dqs_en,
    output var  logic              rtt_dq_en,
    output var  logic              wl_active,
    output var  logic              pda_active,
    output var  logic              cal_en,
    output var  logic              cal_range,
    output var  logic [5:0]        ref_level
);

    localparam logic [3:0] WLO = 4'(`MTMC_WLO_CYC);

    // ====================================================================
    // Parameter check
    if (ADDR_W < 8 || MOD_CK < 1 || MOD_CK > 255 ||
        PDA_WAIT_CK < 2 || PDA_WAIT_CK > 255) begin : g_bad
        $error("mtmc_core: parameter out of range");
    end

    // ====================================================================
    // Pin synchronisers
    logic        ck_s, mrs_n_s, dqs_s, dq0_s, odt_s;
    logic [2:0]  ba_s;
    logic [13:0] a_s;

    mtmc_sync #(.W(22)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .d       ({pin_ck, pin_mrs_n, pin_ba, pin_a, pin_dqs, pin_dq0,
                   pin_odt}),
        .q       ({ck_s, mrs_n_s, ba_s, a_s, dqs_s, dq0_s, odt_s})
    );

    // ====================================================================
    // Mode state
    mtmc_pkg::mtmc_wl_t wl_st_r, wl_st_nxt;
    logic [13:0] mr1_r, mr1_nxt, mr3_r, mr3_nxt, mr6_r, mr6_nxt;
    logic [13:0] pend_a_r, pend_a_nxt;
    logic [2:0]  pend_ba_r, pend_ba_nxt;
    logic        pend_r, pend_nxt, pend_dqs_r, pend_dqs_nxt;
    logic [7:0]  pend_ck_r, pend_ck_nxt, undef_r, undef_nxt;
    logic [15:0] ign_r, ign_nxt;
    logic        ck_d_r, dqs_d_r, fb_r, fb_nxt;
    logic [3:0]  wlo_r, wlo_nxt;
    logic [7:0]  dq_out_nxt;
    logic        dq_oe_nxt, rtt_dqs_nxt, rtt_dq_nxt, wl_act_nxt;
    logic        ctrl_en_r;
    logic        ck_rise, dqs_rise, new_cmd, exe;
    logic [2:0]  exe_ba;
    logic [13:0] exe_a;

    // Command decode, per-device qualification and mode updates
    always_comb begin
        ck_rise      = ck_s & ~ck_d_r;
        dqs_rise     = dqs_s & ~dqs_d_r;
        new_cmd      = ck_rise & ~mrs_n_s & ctrl_en_r;
        exe          = 1'b0;
        exe_ba       = ba_s;
        exe_a        = a_s;
        pend_nxt     = pend_r;
        pend_ba_nxt  = pend_ba_r;
        pend_a_nxt   = pend_a_r;
        pend_dqs_nxt = pend_dqs_r;
        pend_ck_nxt  = pend_ck_r;
        ign_nxt      = ign_r;
        wl_st_nxt    = wl_st_r;
        mr1_nxt      = mr1_r;
        mr3_nxt      = mr3_r;
        mr6_nxt      = mr6_r;
        undef_nxt    = undef_r;
        fb_nxt       = fb_r;
        wlo_nxt      = wlo_r;
        dq_out_nxt   = dq_out;
        // Pending per-device MRS waits for its data bit
        if (pend_r) begin
            if (dqs_rise) begin
                pend_dqs_nxt = 1'b1;
                if (pend_dqs_r) begin
                    pend_nxt = 1'b0;
                    exe      = ~dq0_s;
                    exe_ba   = pend_ba_r;
                    exe_a    = pend_a_r;
                    if (dq0_s) begin
                        ign_nxt = ign_r + 16'h0001;
                    end
                end
            end else if (ck_rise) begin
                pend_ck_nxt = pend_ck_r + 8'h01;
                // Strobe never came: drop rather than hang
                if (pend_ck_r == 8'(PDA_WAIT_CK - 1)) begin
                    pend_nxt = 1'b0;
                    ign_nxt  = ign_r + 16'h0001;
                end
            end
        end
        if (new_cmd) begin
            if (mr3_r[`MTMC_MR3_PDM]) begin
                pend_nxt     = 1'b1;
                pend_ba_nxt  = ba_s;
                pend_a_nxt   = a_s;
                pend_dqs_nxt = 1'b0;
                pend_ck_nxt  = 8'h00;
            end else begin
                exe    = 1'b1;
                exe_ba = ba_s;
                exe_a  = a_s;
            end
        end
        // Exit window counts tMOD link clocks down, then leveling is off
        if (wl_st_r == mtmc_pkg::MTMC_WL_EXIT && ck_rise) begin
            undef_nxt = undef_r - 8'h01;
            if (undef_r == 8'h01) begin
                wl_st_nxt = mtmc_pkg::MTMC_WL_OFF;
            end
        end
        if (exe) begin
            case (exe_ba)
                `MTMC_SEL_MR1: begin
                    if (wl_st_r == mtmc_pkg::MTMC_WL_ON) begin
                        if (!exe_a[`MTMC_MR1_WL]) begin
                            mr1_nxt = (mr1_r & ~`MTMC_MR1_EXIT_M) |
                                      (exe_a & `MTMC_MR1_EXIT_M);
                            wl_st_nxt = mtmc_pkg::MTMC_WL_EXIT;
                            undef_nxt = 8'(MOD_CK);
                        end else begin
                            mr1_nxt[`MTMC_MR1_QOFF] =
                                exe_a[`MTMC_MR1_QOFF];
                        end
                    end else begin
                        mr1_nxt = exe_a;
                        if (exe_a[`MTMC_MR1_WL]) begin
                            wl_st_nxt  = mtmc_pkg::MTMC_WL_ON;
                            wlo_nxt    = 4'h0;
                            dq_out_nxt = 8'h00;
                        end
                    end
                end
                `MTMC_SEL_MR3: begin
                    mr3_nxt = exe_a;
                end
                `MTMC_SEL_MR6: begin
                    // Range is fixed while calibration stays enabled
                    if (!mr6_r[`MTMC_MR6_CAL]) begin
                        mr6_nxt = exe_a;
                    end else if (exe_a[`MTMC_MR6_CAL]) begin
                        mr6_nxt = (mr6_r & ~`MTMC_MR6_LVL_M) |
                                  (exe_a & `MTMC_MR6_LVL_M);
                    end else begin
                        mr6_nxt[`MTMC_MR6_CAL] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Leveling feedback: sample clock level, drive all bits later
        if (wl_st_r == mtmc_pkg::MTMC_WL_ON && dqs_rise) begin
            fb_nxt  = ck_s;
            wlo_nxt = WLO;
        end else if (wlo_r != 4'h0) begin
            wlo_nxt = wlo_r - 4'h1;
            if (wlo_r == 4'h1 && wl_st_r == mtmc_pkg::MTMC_WL_ON) begin
                dq_out_nxt = {8{fb_r}};
            end
        end
        if (wl_st_nxt == mtmc_pkg::MTMC_WL_EXIT) begin
            dq_out_nxt = 8'h00;
        end
        dq_oe_nxt   = ~mr1_nxt[`MTMC_MR1_QOFF] &
                      (wl_st_nxt != mtmc_pkg::MTMC_WL_OFF);
        rtt_dqs_nxt = odt_s;
        rtt_dq_nxt  = odt_s &
                      (wl_st_nxt != mtmc_pkg::MTMC_WL_ON);
        wl_act_nxt  = (wl_st_nxt == mtmc_pkg::MTMC_WL_ON);
    end

    // Mode state registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wl_st_r    <= mtmc_pkg::MTMC_WL_OFF;
            mr1_r      <= `MTMC_MR_RST;
            mr3_r      <= `MTMC_MR_RST;
            mr6_r      <= `MTMC_MR_RST;
            pend_r     <= 1'b0;
            pend_ba_r  <= 3'h0;
            pend_a_r   <= 14'h0000;
            pend_dqs_r <= 1'b0;
            pend_ck_r  <= 8'h00;
            undef_r    <= 8'h00;
            ign_r      <= 16'h0000;
            ck_d_r     <= 1'b0;
            dqs_d_r    <= 1'b0;
            fb_r       <= 1'b0;
            wlo_r      <= 4'h0;
            dq_out     <= 8'h00;
            dq_oe      <= 1'b0;
            rtt_dqs_en <= 1'b0;
            rtt_dq_en  <= 1'b0;
            wl_active  <= 1'b0;
        end else begin
            wl_st_r    <= wl_st_nxt;
            mr1_r      <= mr1_nxt;
            mr3_r      <= mr3_nxt;
            mr6_r      <= mr6_nxt;
            pend_r     <= pend_nxt;
            pend_ba_r  <= pend_ba_nxt;
            pend_a_r   <= pend_a_nxt;
            pend_dqs_r <= pend_dqs_nxt;
            pend_ck_r  <= pend_ck_nxt;
            undef_r    <= undef_nxt;
            ign_r      <= ign_nxt;
            ck_d_r     <= ck_s;
            dqs_d_r    <= dqs_s;
            fb_r       <= fb_nxt;
            wlo_r      <= wlo_nxt;
            dq_out     <= dq_out_nxt;
            dq_oe      <= dq_oe_nxt;
            rtt_dqs_en <= rtt_dqs_nxt;
            rtt_dq_en  <= rtt_dq_nxt;
            wl_active  <= wl_act_nxt;
        end
    end

    // Mode fields go straight out of their register bits
    assign pda_active = mr3_r[`MTMC_MR3_PDM];
    assign cal_en     = mr6_r[`MTMC_MR6_CAL];
    assign cal_range  = mr6_r[`MTMC_MR6_RNG];
    assign ref_level  = mr6_r[5:0];

    // ====================================================================
    // AXI4-Lite slave
    function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
        word_addr = {a[7:2], 2'b00};
    endfunction : word_addr

    logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0]  aw_a_r, aw_a_nxt;
    logic [31:0] w_d_r, w_d_nxt, rdata_nxt;
    logic        w_s_r, w_s_nxt, ctrl_en_nxt;
    logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt;
    logic        rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;

    // Address and data taken in either order; answer one cycle later
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_a_nxt    = aw_a_r;
        w_d_nxt     = w_d_r;
        w_s_nxt     = w_s_r;
        ctrl_en_nxt = ctrl_en_r;
        bvalid_nxt  = s_axi_bvalid & ~s_axi_bready;
        bresp_nxt   = s_axi_bresp;
        rvalid_nxt  = s_axi_rvalid & ~s_axi_rready;
        rresp_nxt   = s_axi_rresp;
        rdata_nxt   = s_axi_rdata;
        arready_nxt = s_axi_arready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_a_nxt    = word_addr(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_d_nxt    = s_axi_wdata;
            w_s_nxt    = s_axi_wstrb[0];
        end
        if (aw_have_r && w_have_r && !s_axi_bvalid) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = `MTMC_RESP_OKAY;
            case (aw_a_r)
                `MTMC_ADDR_CTRL: begin
                    if (w_s_r) begin
                        ctrl_en_nxt = w_d_r[`MTMC_CTRL_EN];
                    end
                end
                `MTMC_ADDR_STAT, `MTMC_ADDR_MR1, `MTMC_ADDR_MR3,
                `MTMC_ADDR_MR6, `MTMC_ADDR_IGN: begin
                end
                default: bresp_nxt = `MTMC_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            arready_nxt = 1'b0;
            rvalid_nxt  = 1'b1;
            rresp_nxt   = `MTMC_RESP_OKAY;
            case (word_addr(s_axi_araddr))
                `MTMC_ADDR_CTRL: rdata_nxt = {31'h0, ctrl_en_r};
                `MTMC_ADDR_STAT: rdata_nxt = {27'h0, pend_r,
                    wl_st_r == mtmc_pkg::MTMC_WL_EXIT, wl_active,
                    mr1_r[`MTMC_MR1_QOFF], pda_active};
                `MTMC_ADDR_MR1:  rdata_nxt = {18'h0, mr1_r};
                `MTMC_ADDR_MR3:  rdata_nxt = {18'h0, mr3_r};
                `MTMC_ADDR_MR6:  rdata_nxt = {18'h0, mr6_r};
                `MTMC_ADDR_IGN:  rdata_nxt = {16'h0, ign_r};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `MTMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            arready_nxt = 1'b1;
        end
        awready_nxt = ~aw_have_nxt;
        wready_nxt  = ~w_have_nxt;
    end

    // Bus registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_a_r        <= 8'h00;
            w_d_r         <= 32'h0;
            w_s_r         <= 1'b0;
            ctrl_en_r     <= `MTMC_CTRL_RST;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MTMC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `MTMC_RESP_OKAY;
            s_axi_rdata   <= 32'h0;
        end else begin
            aw_have_r     <= aw_have_nxt;
            w_have_r      <= w_have_nxt;
            aw_a_r        <= aw_a_nxt;
            w_d_r         <= w_d_nxt;
            w_s_r         <= w_s_nxt;
            ctrl_en_r     <= ctrl_en_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready  <= wready_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rresp   <= rresp_nxt;
            s_axi_rdata   <= rdata_nxt;
        end
    end

    // ====================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_mr1_exe;
        exe && exe_ba == `MTMC_SEL_MR1;
    endsequence
    sequence s_wl_exit;
        s_mr1_exe ##0 wl_st_r == mtmc_pkg::MTMC_WL_ON &&
        !exe_a[`MTMC_MR1_WL];
    endsequence

    AST_WL_ENTRY: assert property (s_mr1_exe ##0 exe_a[`MTMC_MR1_WL] &&
        wl_st_r == mtmc_pkg::MTMC_WL_OFF |=> wl_active ##1 wl_active)
        else $error("leveling not entered");
    AST_QOFF: assert property (mr1_r[`MTMC_MR1_QOFF] |-> !dq_oe)
        else $error("outputs driven while off");
    AST_RTT_DQ: assert property (wl_active |-> !rtt_dq_en)
        else $error("data termination on during leveling");
    AST_EXIT_FIELDS: assert property (s_wl_exit |=>
        (mr1_r & `MTMC_MR1_EXIT_M) == ($past(exe_a) & `MTMC_MR1_EXIT_M))
        else $error("exit fields not applied");
    AST_FEEDBACK: assert property (wl_active && dqs_rise &&
        wl_st_nxt == mtmc_pkg::MTMC_WL_ON ##1 !dqs_rise [*2]
        |=> dq_out == {8{$past(fb_r)}})
        else $error("feedback not driven");
    AST_RTT_DQS: assert property (odt_s |=> rtt_dqs_en)
        else $error("strobe termination missing");
    AST_PDA_IGNORE: assert property (pend_r && pend_dqs_r && dqs_rise &&
        dq0_s && !new_cmd |=> $stable(mr1_r) && $stable(mr3_r) &&
        $stable(mr6_r))
        else $error("disqualified command executed");
    AST_NO_PDA_EXEC: assert property (new_cmd &&
        !mr3_r[`MTMC_MR3_PDM] |-> exe && !pend_nxt)
        else $error("command not executed");
    AST_PDA_EN: assert property (exe && exe_ba == `MTMC_SEL_MR3
        |=> pda_active == $past(exe_a[`MTMC_MR3_PDM]))
        else $error("per-device enable mismatch");
    AST_EXIT_HOLD: assert property (s_wl_exit |=>
        undef_r == 8'(MOD_CK) && dq_out == 8'h00)
        else $error("exit window not started");
    AST_RANGE_HOLD: assert property (cal_en && exe &&
        exe_ba == `MTMC_SEL_MR6 && exe_a[`MTMC_MR6_CAL] |=> $stable(cal_range))
        else $error("range changed during calibration");

endmodule : mtmc_core

`default_nettype wire

// [mtmc_defines.svh]
/*
 Constants of the training mode control block: register offsets, field
 positions, reset values and timing counts.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef MTMC_DEFINES_SVH
`define MTMC_DEFINES_SVH

// ========================================================================
// Register offsets (byte addresses, one word each)
`define MTMC_ADDR_CTRL    8'h00
`define MTMC_ADDR_STAT    8'h04
`define MTMC_ADDR_MR1     8'h08
`define MTMC_ADDR_MR3     8'h0C
`define MTMC_ADDR_MR6     8'h10
`define MTMC_ADDR_IGN     8'h14

// ========================================================================
// Mode register selects and field positions
`define MTMC_SEL_MR1      3'h1
`define MTMC_SEL_MR3      3'h3
`define MTMC_SEL_MR6      3'h6
`define MTMC_MR1_WL       7
`define MTMC_MR1_QOFF     12
`define MTMC_MR3_PDM      4
`define MTMC_MR6_CAL      7
`define MTMC_MR6_RNG      6
`define MTMC_MR1_EXIT_M   14'h1F86
`define MTMC_MR6_LVL_M    14'h003F
`define MTMC_CTRL_EN      0

// ========================================================================
// Reset values and bus answers
`define MTMC_MR_RST       14'h0000
`define MTMC_CTRL_RST     1'h1
`define MTMC_RESP_OKAY    2'h0
`define MTMC_RESP_SLVERR  2'h2

// ========================================================================
// Timing: feedback delay in ns, tMOD and strobe wait in link clocks
`define MTMC_CLK_NS       40
`define MTMC_WLO_NS       40
`define MTMC_WLO_CYC      (((`MTMC_WLO_NS) / (`MTMC_CLK_NS)) < 1 ? 1 : \
                           ((`MTMC_WLO_NS) / (`MTMC_CLK_NS)))
`define MTMC_MOD_CK       24
`define MTMC_PDA_WAIT_CK  16

`endif

// [mtmc_pkg.sv]
/*
 Types of the training mode control block.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package mtmc_pkg;

    // ====================================================================
    // Leveling state, Gray coded along off -> on -> exit; exit -> off flips both bits
    typedef enum logic [1:0] {
        MTMC_WL_OFF  = 2'h0,
        MTMC_WL_ON   = 2'h1,
        MTMC_WL_EXIT = 2'h3
    } mtmc_wl_t;

endpackage : mtmc_pkg

`default_nettype wire

// [mtmc_sync.sv]
/*
 Two-flop synchroniser for a bundle of pin inputs.
 Assumes each bit is a slow level relative to the local clock.
*/
`timescale 1ns/100ps
`default_nettype none

module mtmc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ====================================================================
    // Parameter check
    if (W < 1) begin : g_bad
        $error("mtmc_sync: width below one");
    end

    // ====================================================================
    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : mtmc_sync

`default_nettype wire

// [mtmc_ctl_model.sv]
/* Controller model: free link clock, MRS commands, strobe, data bit 0.
 Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
`default_nettype none
module mtmc_ctl_model (
    output var logic        pin_ck,
    output var logic        pin_mrs_n,
    output var logic [2:0]  pin_ba,
    output var logic [13:0] pin_a,
    output var logic        pin_dqs,
    output var logic        pin_dq0
);
    // ====================================================================
    // Link clock runs free; idle is deselect with strobe low
    initial begin
        {pin_ck, pin_dqs, pin_dq0, pin_ba, pin_a} = '0;
        pin_mrs_n = 1'b1;
        forever #160 pin_ck = ~pin_ck;
    end
    // One rise per trial, 160 ns wide
    task pulse(input int d);
        @(posedge pin_ck);
        #d pin_dqs <= 1'b1;
        #160 pin_dqs <= 1'b0;
    endtask : pulse
    // Spaced commands; bit 0 held through the burst
    task mrs(input logic [2:0] b, input logic [13:0] v, input logic q,
             input logic per_device_mode);
        @(negedge pin_ck);
        {pin_mrs_n, pin_ba, pin_a, pin_dq0} <= {1'b0, b, v, q};
        @(negedge pin_ck);
        pin_mrs_n <= 1'b1;
        pin_a <= ~v;  // Released address lines never keep a stale value
        if (per_device_mode) repeat (2) pulse(80);
        repeat (2) @(negedge pin_ck);
        pin_dq0 <= ~q;
    endtask : mrs
endmodule : mtmc_ctl_model
`default_nettype wire

// [memory_training_mode_control_test.sv]
/* Self-checking bench: registers, calibration, leveling, per-device mode.
 Assumes the design files and the controller model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "mtmc_defines.svh"
module memory_training_mode_control_test;
    logic        clk_sys, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, pin_ck, pin_dqs;
    logic        pin_mrs_n, pin_dq0, pin_odt, dq_oe, rtt_dqs_en, rtt_dq_en;
    logic        wl_active, pda_active, cal_en, cal_range;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, dq_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  pin_ba;
    logic [13:0] pin_a;
    logic [5:0]  ref_level;
    int          fails, checks_done, d, lv;

    mtmc_core #(.MOD_CK(4), .PDA_WAIT_CK(4)) DUT (.*);
    mtmc_ctl_model P (.*);

    // ====================================================================
    // Clock, watchdog well beyond the expected 40 us run
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #400_000 fails++;
        report_and_stop();
    end

    task chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // AXI write: both channels offered, each dropped once taken
    task wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {ad, dt};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask : wr
    task rd(input logic [7:0] ad);
        @(posedge clk_sys);
        s_axi_araddr <= ad;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        {v, r} = {s_axi_rdata, s_axi_rresp};
    endtask : rd
    // Clock level seen by a strobe rise d ns after a link clock rise
    function automatic logic fb(input int d);
        return d < 160;
    endfunction : fb
    task report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // ====================================================================
    // Main sequence
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, pin_odt, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, nrst, fails, checks_done} = '0;
        s_axi_wstrb = 4'hF;
        d = $urandom(32'h5C55);
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`MTMC_ADDR_MR3);
        chk(v, 32'h0);
        rd(8'h40);
        chk(r, `MTMC_RESP_SLVERR);
        wr(8'h40, 32'h0);
        chk(r, `MTMC_RESP_SLVERR);
        wr(`MTMC_ADDR_CTRL, 32'h0);  // Pin commands switched off
        P.mrs(`MTMC_SEL_MR6, 14'h00FF, 1'b0, 1'b0);
        chk(cal_en, 1'b0);
        wr(`MTMC_ADDR_CTRL, 32'h1);
        $display("end of register test");
        repeat (4) begin
            lv = $urandom % 128;
            P.mrs(`MTMC_SEL_MR6, 14'(lv) | 14'h0080, 1'($urandom), 1'b0);
            chk({cal_en, cal_range, ref_level}, 8'h80 | lv);
            // Level step that also flips range: range must stay put
            d = $urandom % 64;
            P.mrs(`MTMC_SEL_MR6, 14'(d + 192 - (lv & 64)), 1'b0, 1'b0);
            chk({cal_en, cal_range, ref_level}, 128 | lv & 64 | d);
            P.mrs(`MTMC_SEL_MR6, 14'h0000, 1'b1, 1'b0);
            chk({cal_en, cal_range, ref_level}, lv & 64 | d);
        end
        $display("end of calibration test");
        pin_odt <= 1'b1;  // Only allowed commands from here
        P.mrs(`MTMC_SEL_MR1, 14'h0080, 1'b0, 1'b0);
        chk({wl_active, dq_oe, rtt_dqs_en, rtt_dq_en}, 4'hE);
        P.mrs(`MTMC_SEL_MR1, 14'h1080, 1'b0, 1'b0);
        rd(`MTMC_ADDR_STAT);
        chk(v[2:1], 2'b11);
        repeat (8) begin
            d = 61 + $urandom % 38 + ($urandom % 2) * 160;
            P.pulse(d);
            repeat (3) @(posedge clk_sys);
            chk(dq_out, {8{fb(d)}});
        end
        pin_odt <= 1'b0;
        P.mrs(`MTMC_SEL_MR1, 14'h0F06, 1'b0, 1'b0);
        chk({wl_active, dq_oe}, 2'b01);
        rd(`MTMC_ADDR_MR1);
        chk(v, 32'h0F06);
        repeat (24) @(posedge clk_sys);
        chk(dq_oe, 1'b0);
        $display("end of leveling test");
        P.mrs(`MTMC_SEL_MR3, 14'h0010, 1'b0, 1'b0);
        chk(pda_active, 1'b1);
        P.mrs(`MTMC_SEL_MR6, 14'h0091, 1'b0, 1'b0);  // No strobe: dropped
        P.mrs(`MTMC_SEL_MR6, 14'h00AA, 1'b1, 1'b1);
        chk(cal_en, 1'b0);
        P.mrs(`MTMC_SEL_MR6, 14'h00AA, 1'b0, 1'b1);
        chk({cal_en, cal_range, ref_level}, 8'hAA);
        P.mrs(`MTMC_SEL_MR3, 14'h0000, 1'b0, 1'b1);
        chk(pda_active, 1'b0);
        rd(`MTMC_ADDR_IGN);
        chk(v, 32'h2);
        $display("end of per-device test");
        report_and_stop();
    end
endmodule : memory_training_mode_control_test
`default_nettype wire
